//--- ccpc_pkg.sv
package ccpc_pkg;
    // register bus
    localparam int CCPC_AW = 4;
    localparam int CCPC_DW = 8;
    localparam logic [3:0] CCPC_OFF_CTRL = 4'h0;
    localparam logic [3:0] CCPC_OFF_DLOW = 4'h1;
    localparam logic [3:0] CCPC_OFF_DHIGH = 4'h2;
    localparam int CCPC_UNIT_STRIDE = 3;
    localparam logic [3:0] CCPC_OFF_PORT_G_DIR = 4'h6;
    localparam logic [3:0] CCPC_OFF_TMR_SEL = 4'h7;
    localparam logic [3:0] CCPC_OFF_STATUS = 4'h8;
    // unit control fields
    localparam logic [7:0] CCPC_CTRL_RST = 8'h00;
    localparam logic [7:0] CCPC_CTRL_WMASK = 8'h3F;
    localparam int CCPC_DUTY_LSB = 4;
    localparam int CCPC_DUTY_MSB = 5;
    // mode field codes
    localparam logic [3:0] CCPC_MODE_OFF = 4'h0;
    localparam logic [3:0] CCPC_MODE_TOGGLE = 4'h2;
    localparam logic [3:0] CCPC_MODE_SET_HI = 4'h8;
    localparam logic [3:0] CCPC_MODE_SET_LO = 4'h9;
    localparam logic [3:0] CCPC_MODE_SOFT = 4'hA;
    localparam logic [3:0] CCPC_MODE_TRIG = 4'hB;
    localparam logic [1:0] CCPC_CLASS_CAPT = 2'h1;
    localparam logic [1:0] CCPC_CLASS_CMP = 2'h2;
    localparam logic [1:0] CCPC_CLASS_PWM = 2'h3;
    // capture edge selections
    localparam logic [1:0] CCPC_EDGE_FALL = 2'h0;
    localparam logic [1:0] CCPC_EDGE_RISE = 2'h1;
    localparam logic [1:0] CCPC_EDGE_4TH = 2'h2;
    localparam logic [1:0] CCPC_EDGE_16TH = 2'h3;
    localparam logic [3:0] CCPC_PRESC_4_LAST = 4'h3;
    localparam logic [3:0] CCPC_PRESC_16_LAST = 4'hF;
    localparam logic [3:0] CCPC_PRESC_RST = 4'h0;
    // port g direction image and status layout
    localparam int CCPC_OD_FIRST_BIT = 5;
    localparam int CCPC_OD_SECOND_BIT = 6;
    localparam int CCPC_STAT_PIN_LSB = 0;
    localparam int CCPC_STAT_FRESH_LSB = 2;
    localparam int CCPC_STAT_OVR_LSB = 4;
    localparam logic [1:0] CCPC_TMR_SEL_RST = 2'h0;
endpackage

//--- ccpc_capt_if.sv
`timescale 1ns/1ps
interface ccpc_capt_if;
    logic pin_level;
    logic capt_en;
    logic [1:0] edge_sel;
    logic capt_evt;
    modport unit (
        input pin_level,
        input capt_en,
        input edge_sel,
        output capt_evt
    );
    modport owner (
        output pin_level,
        output capt_en,
        output edge_sel,
        input capt_evt
    );
endinterface

//--- ccpc_capt.sv
`timescale 1ns/1ps
module ccpc_capt (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // capture control and event
    ccpc_capt_if.unit cap
);
    logic pin_prev_q;
    logic [3:0] presc_q;
    logic evt_q;
    logic [3:0] presc_last;
    wire rise = cap.pin_level & ~pin_prev_q;
    wire fall = ~cap.pin_level & pin_prev_q;
    wire scaled = cap.edge_sel[1];
    wire presc_done = (presc_q & presc_last) == presc_last;

    assign presc_last = (cap.edge_sel == ccpc_pkg::CCPC_EDGE_4TH) ?
        ccpc_pkg::CCPC_PRESC_4_LAST : ccpc_pkg::CCPC_PRESC_16_LAST;
    assign cap.capt_evt = evt_q;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= cap.pin_level;
        end
    end

    // kept across prescale changes, so first capture may come early
    always_ff @(posedge clock_in) begin
        if (rst_in || !cap.capt_en) begin
            presc_q <= ccpc_pkg::CCPC_PRESC_RST; // [RULE_22]
        end else if (scaled && rise) begin
            presc_q <= presc_done ? ccpc_pkg::CCPC_PRESC_RST : presc_q + 4'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in || !cap.capt_en) begin
            evt_q <= 1'b0;
        end else begin
            case (cap.edge_sel) // [RULE_06]
                ccpc_pkg::CCPC_EDGE_FALL: evt_q <= fall;
                ccpc_pkg::CCPC_EDGE_RISE: evt_q <= rise;
                default: evt_q <= rise && presc_done;
            endcase
        end
    end
endmodule // ccpc_capt

//--- ccpc_top.sv
// How it works
// [RULE_01] per unit: control, data low, data high, all read/write
// [RULE_02] control bits 7:6 read zero; others reset to zero
// [RULE_03] control 5:4 are duty low bits; data low the top bits
// [RULE_04] mode 0000 disables and resets the unit
// [RULE_05] mode 0010 toggles pin on match, flags
// [RULE_06] modes 0100-0111 capture on fall, rise, 4th rise, 16th rise
// [RULE_07] mode 1000 starts pin low, match forces high, flags
// [RULE_08] mode 1001 starts pin high, match forces low, flags
// [RULE_09] mode 1010 only flags on match; pin left to port latch
// [RULE_10] mode 1011 flags, clears assigned timer, starts conversion
// [RULE_11] first unit in mode 1011 never starts a conversion
// [RULE_12] modes 11xx are pulse width on the period timer
// [RULE_13] capture and compare use first or third timer only
// [RULE_14] timer select bits pick each unit's timer; units may share
// [RULE_15] one select value gives first timer to unit 0, third to unit 1
// [RULE_16] driven pins may be open drain, driving only low
// [RULE_17] port g direction bits 6 and 5 enable open drain per unit
// [RULE_18] pin select high: second unit on port c bit 1, else e bit 7
// [RULE_19] software sets direction of the second unit's pin; here the unit drives each pin's enable from its mode and the pin select
// [RULE_20] capture loads timer into data, flags; newer overwrites
// [RULE_21] compare data with assigned timer every cycle
// [RULE_22] capture prescaler cleared when off or not capturing only
// [RULE_23] reserved modes 0001 and 0011 leave the unit inert
`timescale 1ns/1ps
module ccpc_top #(
    parameter int DATA_W = 16,
    parameter int DUTY_W = 10
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // register port
    input wire logic [ccpc_pkg::CCPC_AW-1:0] reg_addr_in,
    input wire logic [ccpc_pkg::CCPC_DW-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [ccpc_pkg::CCPC_DW-1:0] reg_rdata_out,
    // shared timers
    input wire logic [DATA_W-1:0] first_timer_count_in,
    input wire logic [DATA_W-1:0] third_timer_count_in,
    input wire logic [DUTY_W-1:0] period_count_in,
    input wire logic period_match_in,
    // configuration
    input wire logic second_pin_select_in,
    // first unit pin
    input wire logic first_unit_pin_in,
    output logic first_unit_pin_out,
    output logic first_unit_pin_oe_n_out,
    // second unit pins
    input wire logic port_c_bit1_in,
    output logic port_c_bit1_out,
    output logic port_c_bit1_oe_n_out,
    input wire logic port_e_bit7_in,
    output logic port_e_bit7_out,
    output logic port_e_bit7_oe_n_out,
    // events to the rest of the chip
    output logic [1:0] unit_irq_flag_out,
    output logic first_timer_clear_out,
    output logic third_timer_clear_out,
    output logic adc_start_out
);
    localparam int NUNITS = 2;

    // shared registers
    logic [1:0] od_q;
    logic [1:0] tmr_sel_q;
    logic [ccpc_pkg::CCPC_DW-1:0] rdata_q;
    logic [1:0] irq_q;
    logic first_clr_q;
    logic third_clr_q;
    logic adc_q;
    logic u0_out_q;
    logic u0_oe_n_q;
    logic c1_out_q;
    logic c1_oe_n_q;
    logic e7_out_q;
    logic e7_oe_n_q;

    // per-unit results
    logic [NUNITS-1:0] use_third;
    logic [NUNITS-1:0] pin_lvl;
    logic [NUNITS-1:0] drives;
    logic [NUNITS-1:0] irq_set;
    logic [NUNITS-1:0] trig;
    logic [NUNITS-1:0] cap_pin;
    logic [NUNITS-1:0] fresh;
    logic [NUNITS-1:0] ovr;
    logic [NUNITS-1:0] unit_hit;
    logic [ccpc_pkg::CCPC_DW-1:0] unit_rd [NUNITS];
    logic [ccpc_pkg::CCPC_DW-1:0] rd_mux;

    wire wr_od = reg_wr_in && reg_addr_in == ccpc_pkg::CCPC_OFF_PORT_G_DIR;
    wire wr_sel = reg_wr_in && reg_addr_in == ccpc_pkg::CCPC_OFF_TMR_SEL;
    wire wr_stat = reg_wr_in && reg_addr_in == ccpc_pkg::CCPC_OFF_STATUS;
    wire [1:0] ovr_clr =
        wr_stat ? reg_wdata_in[ccpc_pkg::CCPC_STAT_OVR_LSB +: 2] : 2'h0;

    // select 00: both first timer; 01: unit 0 first, unit 1 third;
    // 1x: both third timer
    assign use_third[0] = tmr_sel_q[1]; // [RULE_14]
    assign use_third[1] = tmr_sel_q[1] | tmr_sel_q[0]; // [RULE_15]

    // unused second pin is released
    assign cap_pin[0] = first_unit_pin_in;
    assign cap_pin[1] = second_pin_select_in ? port_c_bit1_in
        : port_e_bit7_in; // [RULE_18]

    genvar u;
    generate
        for (u = 0; u < NUNITS; u++) begin : g_unit
            localparam logic [3:0] BASE = 4'(u * ccpc_pkg::CCPC_UNIT_STRIDE);
            localparam logic [3:0] A_CTRL = BASE + ccpc_pkg::CCPC_OFF_CTRL;
            localparam logic [3:0] A_DLOW = BASE + ccpc_pkg::CCPC_OFF_DLOW;
            localparam logic [3:0] A_DHIGH = BASE + ccpc_pkg::CCPC_OFF_DHIGH;

            logic [7:0] ctrl_q;
            logic [7:0] dlow_q;
            logic [7:0] dhigh_q;
            logic [1:0] duty_lsb_q;
            logic [3:0] mode_prev_q;
            logic match_prev_q;
            logic pin_q;
            logic fresh_q;
            logic ovr_q;

            ccpc_capt_if cap_if ();

            wire [3:0] mode = ctrl_q[3:0];
            wire [1:0] mclass = mode[3:2];
            wire is_pwm = mclass == ccpc_pkg::CCPC_CLASS_PWM; // [RULE_12]
            wire is_cap = mclass == ccpc_pkg::CCPC_CLASS_CAPT;
            // reserved 0001/0011 fall in no class and stay inert
            wire is_cmp = mclass == ccpc_pkg::CCPC_CLASS_CMP ||
                mode == ccpc_pkg::CCPC_MODE_TOGGLE; // [RULE_23]
            wire is_off = !(is_pwm || is_cap || is_cmp); // [RULE_04]
            wire entered = mode != mode_prev_q;
            // software interrupt and trigger modes leave the pin alone
            wire cmp_drives = is_cmp && mode != ccpc_pkg::CCPC_MODE_SOFT &&
                mode != ccpc_pkg::CCPC_MODE_TRIG; // [RULE_09]
            wire [DATA_W-1:0] tbase = use_third[u] ? third_timer_count_in
                : first_timer_count_in;
            wire [DATA_W-1:0] data = {dhigh_q, dlow_q};
            // act on the first matching cycle only, a stalled timer
            // would otherwise toggle the pin every clock
            wire match = is_cmp && data == tbase; // [RULE_13] [RULE_21]
            wire match_rise = match && !match_prev_q;
            wire cap_evt = cap_if.capt_evt;
            wire [DUTY_W-1:0] duty_next = {dlow_q, ctrl_q[5:4]}; // [RULE_03]
            wire [DUTY_W-1:0] duty_run = {dhigh_q, duty_lsb_q};
            wire wr_ctrl = reg_wr_in && reg_addr_in == A_CTRL;
            wire wr_dlow = reg_wr_in && reg_addr_in == A_DLOW;
            wire wr_dhigh = reg_wr_in && reg_addr_in == A_DHIGH;
            wire rd_dhigh = reg_rd_in && reg_addr_in == A_DHIGH;

            assign cap_if.pin_level = cap_pin[u];
            assign cap_if.capt_en = is_cap;
            assign cap_if.edge_sel = mode[1:0];

            ccpc_capt u_capt (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .cap(cap_if.unit)
            );

            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    ctrl_q <= ccpc_pkg::CCPC_CTRL_RST; // [RULE_02]
                end else if (wr_ctrl) begin
                    ctrl_q <= reg_wdata_in & ccpc_pkg::CCPC_CTRL_WMASK;
                end
            end

            // capture beats a same-cycle write
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    dlow_q <= 8'h00;
                    dhigh_q <= 8'h00;
                end else if (cap_evt) begin
                    {dhigh_q, dlow_q} <= tbase; // [RULE_20]
                end else begin
                    if (is_pwm && period_match_in) begin
                        dhigh_q <= dlow_q;
                    end
                    if (wr_dlow) begin
                        dlow_q <= reg_wdata_in; // [RULE_01]
                    end
                    if (wr_dhigh) begin
                        dhigh_q <= reg_wdata_in;
                    end
                end
            end

            // duty low bits act at period wrap
            always_ff @(posedge clock_in) begin
                if (rst_in || is_off) begin
                    duty_lsb_q <= 2'h0;
                end else if (is_pwm && period_match_in) begin
                    duty_lsb_q <= ctrl_q[ccpc_pkg::CCPC_DUTY_MSB:
                        ccpc_pkg::CCPC_DUTY_LSB];
                end
            end

            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    mode_prev_q <= ccpc_pkg::CCPC_MODE_OFF;
                    match_prev_q <= 1'b0;
                end else begin
                    mode_prev_q <= mode;
                    match_prev_q <= match;
                end
            end

            always_ff @(posedge clock_in) begin
                if (rst_in || is_off) begin
                    pin_q <= 1'b0; // [RULE_04]
                end else if (is_pwm) begin
                    if (period_match_in) begin
                        pin_q <= duty_next != '0;
                    end else if (period_count_in == duty_run) begin
                        pin_q <= 1'b0;
                    end
                end else if (entered && mode == ccpc_pkg::CCPC_MODE_SET_HI) begin
                    pin_q <= 1'b0; // [RULE_07]
                end else if (entered && mode == ccpc_pkg::CCPC_MODE_SET_LO) begin
                    pin_q <= 1'b1; // [RULE_08]
                end else if (match_rise) begin
                    case (mode)
                        ccpc_pkg::CCPC_MODE_TOGGLE: pin_q <= !pin_q; // [RULE_05]
                        ccpc_pkg::CCPC_MODE_SET_HI: pin_q <= 1'b1; // [RULE_07]
                        ccpc_pkg::CCPC_MODE_SET_LO: pin_q <= 1'b0; // [RULE_08]
                        default: pin_q <= pin_q;
                    endcase
                end
            end

            // unread capture; capture beats clear
            always_ff @(posedge clock_in) begin
                if (rst_in || is_off) begin
                    fresh_q <= 1'b0;
                    ovr_q <= 1'b0;
                end else begin
                    fresh_q <= cap_evt || (fresh_q && !rd_dhigh);
                    ovr_q <= (cap_evt && fresh_q) || (ovr_q && !ovr_clr[u]);
                end
            end

            assign irq_set[u] = match_rise || cap_evt; // [RULE_05] [RULE_20]
            assign trig[u] = match_rise && mode == ccpc_pkg::CCPC_MODE_TRIG;
            assign pin_lvl[u] = pin_q;
            assign drives[u] = cmp_drives || is_pwm;
            assign fresh[u] = fresh_q;
            assign ovr[u] = ovr_q;
            assign unit_hit[u] = reg_addr_in == A_CTRL ||
                reg_addr_in == A_DLOW || reg_addr_in == A_DHIGH;
            assign unit_rd[u] = reg_addr_in == A_CTRL ? ctrl_q :
                reg_addr_in == A_DLOW ? dlow_q :
                reg_addr_in == A_DHIGH ? dhigh_q : 8'h00;
        end
    endgenerate

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            od_q <= 2'h0;
            tmr_sel_q <= ccpc_pkg::CCPC_TMR_SEL_RST;
        end else begin
            if (wr_od) begin
                od_q <= {reg_wdata_in[ccpc_pkg::CCPC_OD_SECOND_BIT],
                         reg_wdata_in[ccpc_pkg::CCPC_OD_FIRST_BIT]}; // [RULE_17]
            end
            if (wr_sel) begin
                tmr_sel_q <= reg_wdata_in[1:0];
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        if (unit_hit[0]) begin
            rd_mux = unit_rd[0];
        end else if (unit_hit[1]) begin
            rd_mux = unit_rd[1];
        end else if (reg_addr_in == ccpc_pkg::CCPC_OFF_PORT_G_DIR) begin
            rd_mux[ccpc_pkg::CCPC_OD_FIRST_BIT] = od_q[0];
            rd_mux[ccpc_pkg::CCPC_OD_SECOND_BIT] = od_q[1];
        end else if (reg_addr_in == ccpc_pkg::CCPC_OFF_TMR_SEL) begin
            rd_mux[1:0] = tmr_sel_q;
        end else if (reg_addr_in == ccpc_pkg::CCPC_OFF_STATUS) begin
            rd_mux[ccpc_pkg::CCPC_STAT_PIN_LSB +: 2] = pin_lvl;
            rd_mux[ccpc_pkg::CCPC_STAT_FRESH_LSB +: 2] = fresh;
            rd_mux[ccpc_pkg::CCPC_STAT_OVR_LSB +: 2] = ovr;
        end
    end

    // read data stands one cycle
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    // one-cycle event pulses
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            irq_q <= 2'h0;
            first_clr_q <= 1'b0;
            third_clr_q <= 1'b0;
            adc_q <= 1'b0;
        end else begin
            irq_q <= irq_set;
            first_clr_q <= |(trig & ~use_third); // [RULE_10]
            third_clr_q <= |(trig & use_third); // [RULE_10]
            adc_q <= trig[1]; // [RULE_11]
        end
    end

    // open drain releases high
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            u0_out_q <= 1'b0;
            u0_oe_n_q <= 1'b1;
            c1_out_q <= 1'b0;
            c1_oe_n_q <= 1'b1;
            e7_out_q <= 1'b0;
            e7_oe_n_q <= 1'b1;
        end else begin
            u0_out_q <= pin_lvl[0] && !od_q[0];
            u0_oe_n_q <= !drives[0] || (od_q[0] && pin_lvl[0]); // [RULE_16]
            c1_out_q <= pin_lvl[1] && !od_q[1];
            c1_oe_n_q <= !(drives[1] && second_pin_select_in) ||
                (od_q[1] && pin_lvl[1]); // [RULE_16] [RULE_18]
            e7_out_q <= pin_lvl[1] && !od_q[1];
            e7_oe_n_q <= !(drives[1] && !second_pin_select_in) ||
                (od_q[1] && pin_lvl[1]); // [RULE_16] [RULE_18]
        end
    end

    // pin direction follows the unit mode, open drain and pin select
    assign reg_rdata_out = rdata_q;
    assign unit_irq_flag_out = irq_q;
    assign first_timer_clear_out = first_clr_q;
    assign third_timer_clear_out = third_clr_q;
    assign adc_start_out = adc_q;
    assign first_unit_pin_out = u0_out_q;
    assign first_unit_pin_oe_n_out = u0_oe_n_q;
    assign port_c_bit1_out = c1_out_q;
    assign port_c_bit1_oe_n_out = c1_oe_n_q;
    assign port_e_bit7_out = e7_out_q;
    assign port_e_bit7_oe_n_out = e7_oe_n_q;
endmodule // ccpc_top

//--- ccpc_top_asserts.sv
`timescale 1ns/1ps
module ccpc_top_asserts (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // pins and events
    input wire logic second_pin_select_in,
    input wire logic first_unit_pin_out,
    input wire logic first_unit_pin_oe_n_out,
    input wire logic port_c_bit1_oe_n_out,
    input wire logic port_e_bit7_oe_n_out,
    input wire logic [1:0] unit_irq_flag_out,
    input wire logic first_timer_clear_out,
    input wire logic third_timer_clear_out,
    input wire logic adc_start_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic [7:0] ctrl0_q;
    logic od0_q;
    wire wr_ctrl0 = reg_wr_in && reg_addr_in == 4'h0;
    wire wr_dir = reg_wr_in && reg_addr_in == 4'h6;
    wire inert0 = ctrl0_q[3:0] == 4'h0 || ctrl0_q[3:0] == 4'h1 ||
        ctrl0_q[3:0] == 4'h3;
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl0_q <= 8'h00;
            od0_q <= 1'b0;
        end else begin
            if (wr_ctrl0) ctrl0_q <= reg_wdata_in & 8'h3F;
            if (wr_dir) od0_q <= reg_wdata_in[5];
        end
    end
    sequence s_sel_hi; second_pin_select_in [*3]; endsequence
    sequence s_sel_lo; !second_pin_select_in [*3]; endsequence
    sequence s_inert0; inert0 [*3]; endsequence
    sequence s_od0; od0_q [*3]; endsequence
    property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
    property p_ctrl_rd;
        reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out == $past(ctrl0_q);
    endproperty
    property p_top_zero;
        reg_rd_in && reg_addr_in == 4'h3 |=> reg_rdata_out[7:6] == 2'h0;
    endproperty
    property p_unmapped;
        reg_rd_in && reg_addr_in > 4'h8 |=> reg_rdata_out == 8'h00;
    endproperty
    property p_adc_irq; adc_start_out |-> unit_irq_flag_out[1]; endproperty
    property p_adc_clr;
        adc_start_out |-> third_timer_clear_out || first_timer_clear_out;
    endproperty
    property p_clr_irq;
        first_timer_clear_out || third_timer_clear_out |-> |unit_irq_flag_out;
    endproperty
    property p_od;
        s_od0 ##0 !first_unit_pin_oe_n_out |-> !first_unit_pin_out;
    endproperty
    property p_sel_hi; s_sel_hi |-> port_e_bit7_oe_n_out; endproperty
    property p_sel_lo; s_sel_lo |-> port_c_bit1_oe_n_out; endproperty
    property p_inert; s_inert0 |-> first_unit_pin_oe_n_out; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle");
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl");
    a_top_zero: assert property (p_top_zero) else $error("top");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_adc_irq: assert property (p_adc_irq) else $error("adc");
    a_adc_clr: assert property (p_adc_clr) else $error("clr");
    a_clr_irq: assert property (p_clr_irq) else $error("flag");
    a_od: assert property (p_od) else $error("od high");
    a_sel_hi: assert property (p_sel_hi) else $error("port e");
    a_sel_lo: assert property (p_sel_lo) else $error("port c");
    a_inert: assert property (p_inert) else $error("inert");
endmodule // ccpc_top_asserts

//--- ccpc_partner.sv
`timescale 1ns/1ps
module ccpc_partner #(
    parameter int PERIOD = 40
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // clear requests
    input wire logic first_clear_in,
    input wire logic third_clear_in,
    // timer counts
    output logic [15:0] first_count_out,
    output logic [15:0] third_count_out,
    output logic [9:0] period_count_out,
    output logic period_match_out
);
    // third timer steps by 3 so a wrong timer choice matches late or not at all
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            first_count_out <= 16'h0000;
            third_count_out <= 16'h0000;
            period_count_out <= 10'h000;
            period_match_out <= 1'b0;
        end else begin
            first_count_out <= first_clear_in ? 16'h0000 :
                               first_count_out + 16'h0001;
            third_count_out <= third_clear_in ? 16'h0000 :
                               third_count_out + 16'h0003;
            period_match_out <= period_count_out == 10'(PERIOD - 1);
            period_count_out <= period_count_out == 10'(PERIOD - 1) ?
                                10'h000 : period_count_out + 10'h001;
        end
    end
endmodule // ccpc_partner

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    logic clock_in, rst_in, reg_wr_in, reg_rd_in, sel, lvl, pm;
    logic [3:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    logic [15:0] t1, t3;
    logic [9:0] pc;
    logic p1_out, p1_oe_n, pc_out, pc_oe_n, pe_out, pe_oe_n, clr1, clr3, adc;
    logic [1:0] irq;
    // own drive, else outside level
    wire p1_w = p1_oe_n ? lvl : p1_out;
    wire pc_w = pc_oe_n ? lvl : pc_out;
    wire pe_w = pe_oe_n ? lvl : pe_out;
    int errors = 0;
    int cmp_count = 0;
    int irq0_cnt = 0;
    ccpc_top i_dut (.clock_in, .rst_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .first_timer_count_in(t1),
        .third_timer_count_in(t3), .period_count_in(pc),
        .period_match_in(pm), .second_pin_select_in(sel),
        .first_unit_pin_in(p1_w), .first_unit_pin_out(p1_out),
        .first_unit_pin_oe_n_out(p1_oe_n), .port_c_bit1_in(pc_w),
        .port_c_bit1_out(pc_out), .port_c_bit1_oe_n_out(pc_oe_n),
        .port_e_bit7_in(pe_w), .port_e_bit7_out(pe_out),
        .port_e_bit7_oe_n_out(pe_oe_n), .unit_irq_flag_out(irq),
        .first_timer_clear_out(clr1), .third_timer_clear_out(clr3),
        .adc_start_out(adc));
    ccpc_partner i_partner (.clock_in, .rst_in,
        .first_clear_in(clr1), .third_clear_in(clr3),
        .first_count_out(t1), .third_count_out(t3),
        .period_count_out(pc), .period_match_out(pm));
    always @(posedge clock_in) if (irq[0] === 1'b1) irq0_cnt++;
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        cyc(0);
        v = reg_rdata_out;
    endtask
    task rw(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
        logic [7:0] v;
        wr(a, d);
        rd(a, v);
        `CHK(v, e)
    endtask
    task set_data(input logic [3:0] a, input logic [15:0] v);
        wr(a + 4'h1, v[15:8]);
        wr(a, v[7:0]);
    endtask
    task wait_irq(input int u);
        int k;
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (irq[u] !== 1'b1 && k < 200);
        if (irq[u] !== 1'b1) begin
            errors++;
            end_sim();
        end
    endtask
    task t_regs;
        rw(4'h0, 8'h00, 8'h00);
        rw(4'h0, 8'hFF, 8'h3F);
        rw(4'h3, 8'hC0, 8'h00);
        rw(4'h1, 8'hA5, 8'hA5);
        rw(4'h5, 8'h5A, 8'h5A);
        rw(4'h6, 8'hFF, 8'h60);
        rw(4'hF, 8'h77, 8'h00);
        wr(4'h6, 8'h00);
        wr(4'h0, 8'h00);
        $display("regs done");
    endtask
    task t_toggle;
        set_data(4'h1, t1 + 16'h0020);
        wr(4'h0, 8'h02);
        wait_irq(0);
        cyc(1);
        `CHK({p1_oe_n, p1_out}, 2'b01)
        wr(4'h0, 8'h00);
        $display("toggle done");
    endtask
    task t_trig;
        wr(4'h7, 8'h01);
        set_data(4'h4, t3 + 16'h0021);
        wr(4'h3, 8'h0B);
        wait_irq(1);
        `CHK({clr1, clr3, adc}, 3'b011)
        wr(4'h3, 8'h00);
        set_data(4'h1, t1 + 16'h0020);
        wr(4'h0, 8'h0B);
        wait_irq(0);
        `CHK({clr1, clr3, adc}, 3'b100)
        wr(4'h0, 8'h00);
        wr(4'h7, 8'h00);
        $display("trigger done");
    endtask
    task t_capt;
        int m, n0;
        int cnt_exp[4] = '{16, 16, 4, 1};
        logic [7:0] lo, hi;
        logic [15:0] tv;
        for (m = 4; m < 8; m++) begin
            wr(4'h0, 8'(m));
            n0 = irq0_cnt;
            repeat (16) begin
                cyc(3);
                lvl <= 1'b1;
                tv = t1;
                cyc(3);
                lvl <= 1'b0;
            end
            cyc(4);
            `CHK(irq0_cnt - n0, cnt_exp[m - 4])
            wr(4'h0, 8'h00);
        end
        rd(4'h1, lo);
        rd(4'h2, hi);
        `CHK(({hi, lo} - tv) <= 16'h0004, 1'b1)
        $display("capture done");
    endtask
    task t_od;
        wr(4'h6, 8'h20);
        set_data(4'h1, t1 + 16'h0020);
        wr(4'h0, 8'h08);
        cyc(2);
        `CHK({p1_oe_n, p1_out}, 2'b00)
        wait_irq(0);
        cyc(1);
        `CHK(p1_oe_n, 1'b1)
        wr(4'h0, 8'h00);
        wr(4'h6, 8'h00);
        $display("open drain done");
    endtask
    task t_psel;
        set_data(4'h4, t3 - 16'h0003);
        wr(4'h3, 8'h09);
        cyc(3);
        `CHK({pc_oe_n, pc_out, pe_oe_n}, 3'b011)
        sel <= 1'b0;
        cyc(4);
        `CHK({pc_oe_n, pe_oe_n, pe_out}, 3'b101)
        wr(4'h3, 8'h00);
        sel <= 1'b1;
        $display("pin select done");
    endtask
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    initial begin
        rst_in = 1'b1;
        reg_addr_in = 4'h0;
        reg_wdata_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        sel = 1'b1;
        lvl = 1'b0;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        t_regs();
        t_toggle();
        t_trig();
        t_capt();
        t_od();
        t_psel();
        end_sim();
    end
endmodule // tb_top
bind ccpc_top ccpc_top_asserts i_chk (.*);
